/* File: src/dasi_consts.svh */
`ifndef DASI_CONSTS_SVH
`define DASI_CONSTS_SVH
// ----
// frame and word layout
// ----
`define DASI_CMD_W 16
`define DASI_CRC_W 8
`define DASI_RX_W 24
`define DASI_LINE_W 44
`define DASI_RES_MAX 18
`define DASI_BOOST_BITS 2
`define DASI_CNT_W 6
`define DASI_CNT_MAX 6'h3F
`define DASI_CMD_RW_BIT 15
`define DASI_CMD_ADDR_HI 14
`define DASI_CMD_ADDR_LO 12
`define DASI_CMD_DATA_HI 11
`define DASI_IDLE_CMD 16'h0000
// ----
// checksum
// ----
`define DASI_CRC_POLY 8'h07
`define DASI_CRC_INIT 8'hFF
// ----
// register file
// ----
`define DASI_REG_W 12
`define DASI_REG_N 8
`define DASI_REG_RESET 12'h000
`define DASI_REG_SETUP1 3'h1
`define DASI_REG_SETUP2 3'h2
`define DASI_S1_OSR_HI 8
`define DASI_S1_OSR_LO 6
`define DASI_S1_BOOST_BIT 2
`define DASI_S1_CRC_R_BIT 10
`define DASI_S1_CRC_W_BIT 11
`define DASI_S2_LANE_BIT 8
// ----
// timing
// ----
`define DASI_CORE_MHZ 125
`define DASI_CONV_TIME_NS 250
`define DASI_CONV_CYC ((`DASI_CONV_TIME_NS*`DASI_CORE_MHZ+999)/1000)
`endif

/* File: src/dasi_pkg.sv */
package dasi_pkg;
    // conversion sequencer states
    typedef enum logic [0:0] {
        DASI_CV_IDLE = 1'b0,
        DASI_CV_RUN = 1'b1
    } dasi_conv_state_t;
    // one register of the setup file
    typedef logic [11:0] dasi_reg_t;
endpackage

/* File: src/dasi_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// two flip-flop level synchroniser
// ----
module dasi_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous level in, synchronised level out
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q; // first stage, read only by the second

    // both stages shift every edge
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_q <= RST_VAL;
            q_o <= RST_VAL;
        end
        else
        begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule // dasi_sync
`default_nettype wire

/* File: src/dasi_crc8.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dasi_consts.svh"
// ----
// combinational checksum over a left-aligned message
// ----
module dasi_crc8 #(
    parameter int DW = 36
) (
    // message, first bit at the top, and its length in bits
    input wire logic [DW-1:0] data_i,
    input wire logic [5:0] len_i,
    // remainder
    output logic [7:0] crc_o
);
    logic [7:0] rem; // running remainder
    logic fb; // feedback bit

    // preset of all ones equals inverting the first eight message bits
    always_comb
    begin
        rem = `DASI_CRC_INIT;
        fb = 1'b0;
        for (int i = 0; i < DW; i++)
        begin
            if (i < int'(len_i))
            begin
                fb = rem[7] ^ data_i[DW-1-i];
                rem = {rem[6:0], 1'b0} ^ (fb ? `DASI_CRC_POLY : 8'h00);
            end
        end
        crc_o = rem;
    end
endmodule // dasi_crc8
`default_nettype wire

/* File: src/dasi_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dasi_consts.svh"
// What this block does
// - chip select fall samples, converts, drives outputs
// - conversion timed by core clock, not serial
// - results appear in the following frame
// - result width sixteen or eighteen bits
// - msb at select fall, rest on rising
// - select rise returns outputs to high impedance
// - lane select zero: A first, B second
// - single lane: A then B on first
// - boost with oversampling widens results two bits
// - second select pulse reads the fresh result
// - top bit zero: register read, address field
// - top bit one: write twelve data bits
// - write is sixteen or twenty-four bits
// - separate read and write checksum enables
// - read checksum appended after results and registers
// - writes lacking valid checksum are discarded
// - checksum polynomial x8 x2 x 1
// - result checksum over both channels, top inverted
// - register word checksum uses same procedure
module dasi_top #(
    parameter int RESULT_BITS = 16
) (
    // core clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // serial link
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdi_i,
    output logic first_serial_output_o,
    output logic first_serial_output_oe_o,
    output logic second_serial_output_o,
    output logic second_serial_output_oe_o,
    // converter cores
    output logic sample_hold_o,
    output logic conv_busy_o,
    input wire logic [17:0] conv_a_i,
    input wire logic [17:0] conv_b_i,
    // setup and status
    output logic [2:0] osr_o,
    output logic resolution_boost_enable_o,
    output logic output_lane_select_o,
    output logic crc_read_en_o,
    output logic crc_write_en_o,
    output logic write_reject_o,
    output logic reg_read_pending_o
);
    // ----
    // declarations
    // ----
    localparam int LW = `DASI_LINE_W;
    localparam int CONV_CYC = `DASI_CONV_CYC;
    logic frame_off; // link idle: reset or select high
    logic first_q; // no serial clock seen yet in this frame
    logic [5:0] cnt_q; // serial clocks seen in last frame
    logic [23:0] rx_q; // last bits received on the input
    logic [5:0] bit_idx; // index of bit now on the outputs
    logic [LW-1:0] line0_q; // payload for the first output
    logic [LW-1:0] line1_q; // payload for the second output
    logic [LW-1:0] line0_d;
    logic [LW-1:0] line1_d;
    logic cs_s; // synchronised select, high when idle
    logic cs_d_q; // its previous value
    logic cs_fall;
    logic cs_rise;
    dasi_pkg::dasi_conv_state_t cv_q; // conversion sequencer
    logic [5:0] cv_tmr_q; // cycles left in conversion
    logic [17:0] data_a_q; // latest converter A result
    logic [17:0] data_b_q; // latest converter B result
    dasi_pkg::dasi_reg_t regs_q [`DASI_REG_N]; // setup registers
    dasi_pkg::dasi_reg_t setup1;
    dasi_pkg::dasi_reg_t setup2;
    logic rd_pend_q; // next frame carries a register word
    logic [2:0] rd_addr_q; // register to return
    logic [15:0] cmd; // command word of the last frame
    logic [7:0] rx_crc; // checksum byte of the last frame
    logic long_frame; // frame carried a checksum byte
    logic cmd_valid; // frame long enough for a command
    logic sets_crcw; // write turns on write checking
    logic need_crc; // write must carry a valid checksum
    logic wr_ok; // write is applied
    logic [7:0] wr_crc; // checksum computed over cmd
    logic boost; // widened results in force
    logic [5:0] w; // result width now in force
    logic [17:0] a_l; // results left-aligned in 18 bits
    logic [17:0] b_l;
    logic [35:0] ab; // both results back to back
    logic [15:0] reg_word; // register read word
    logic [35:0] crc_msg; // message fed to the checksum
    logic [5:0] crc_len;
    logic [7:0] rd_crc; // read checksum
    logic [7:0] rd_crc_m; // read checksum, zero when disabled

    // ----
    // link domain
    // ----
    // idle pulls the frame back to its first bit; glitch-free pin only
    assign frame_off = sys_rst_i | spi_cs_n_i;

    // marks the start of a frame until the first rising serial clock
    always_ff @(posedge spi_sclk_i or posedge frame_off)
    begin
        if (frame_off)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end

    // counts serial clocks; value survives the frame for the core
    always_ff @(posedge spi_sclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cnt_q <= 6'h00;
        else if (first_q)
            cnt_q <= 6'h01;
        else if (cnt_q != `DASI_CNT_MAX)
            cnt_q <= cnt_q + 6'h01;
    end

    // shifts in command bits, last 24 kept
    always_ff @(posedge spi_sclk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            rx_q <= 24'h00_0000;
        else
            rx_q <= {rx_q[22:0], spi_sdi_i};
    end

    // msb shows at select fall, later bits move on rising clocks
    assign bit_idx = first_q ? 6'h00 : cnt_q;

    // outputs driven only inside a frame
    always_comb
    begin
        first_serial_output_o = 1'b0;
        second_serial_output_o = 1'b0;
        if (int'(bit_idx) < LW)
        begin
            first_serial_output_o = line0_q[LW-1-int'(bit_idx)];
            second_serial_output_o = line1_q[LW-1-int'(bit_idx)];
        end
    end
    assign first_serial_output_oe_o = ~spi_cs_n_i;
    // single lane leaves the second output undriven
    assign second_serial_output_oe_o =
        ~spi_cs_n_i & ~output_lane_select_o;

    // ----
    // select crossing
    // ----
    dasi_sync #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_cs_sync (
        .clk_i(core_clk_i),
        .rst_i(sys_rst_i),
        .d_i(spi_cs_n_i),
        .q_o(cs_s)
    );

    // previous synchronised select for edge detection
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            cs_d_q <= 1'b1;
        else
            cs_d_q <= cs_s;
    end
    assign cs_fall = cs_d_q & ~cs_s;
    assign cs_rise = ~cs_d_q & cs_s;

    // ----
    // conversion sequencer
    // ----
    // each select fall samples both inputs and starts a conversion
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            cv_q <= dasi_pkg::DASI_CV_IDLE;
            cv_tmr_q <= 6'h00;
        end
        else if (cs_fall)
        begin
            // a fall mid-conversion restarts it
            cv_q <= dasi_pkg::DASI_CV_RUN;
            cv_tmr_q <= 6'(CONV_CYC - 1);
        end
        else
        begin
            case (cv_q)
                dasi_pkg::DASI_CV_IDLE:
                    cv_q <= dasi_pkg::DASI_CV_IDLE;
                dasi_pkg::DASI_CV_RUN:
                begin
                    // timed by the core clock alone
                    if (cv_tmr_q == 6'h00)
                        cv_q <= dasi_pkg::DASI_CV_IDLE;
                    else
                        cv_tmr_q <= cv_tmr_q - 6'h01;
                end
                default:
                    cv_q <= dasi_pkg::DASI_CV_IDLE;
            endcase
        end
    end
    assign sample_hold_o = cs_fall;
    assign conv_busy_o = (cv_q == dasi_pkg::DASI_CV_RUN);

    // results captured as the conversion ends
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            data_a_q <= 18'h0_0000;
            data_b_q <= 18'h0_0000;
        end
        else if (cv_q == dasi_pkg::DASI_CV_RUN && cv_tmr_q == 6'h00
                 && !cs_fall)
        begin
            data_a_q <= conv_a_i;
            data_b_q <= conv_b_i;
        end
    end

    // ----
    // command decode
    // ----
    // link words are still while select is high, so read them here
    assign long_frame = (cnt_q >= 6'h18);
    assign cmd_valid = (cnt_q >= 6'h10);
    assign cmd = long_frame ? rx_q[23:8] : rx_q[15:0];
    assign rx_crc = rx_q[7:0];
    assign sets_crcw = cmd[`DASI_CMD_RW_BIT]
        && cmd[`DASI_CMD_ADDR_HI:`DASI_CMD_ADDR_LO] == `DASI_REG_SETUP1
        && cmd[`DASI_S1_CRC_W_BIT];
    // checking applies once on, and to the frame turning it on
    assign need_crc = crc_write_en_o | sets_crcw;
    assign wr_ok = cmd_valid && cmd[`DASI_CMD_RW_BIT]
        && (!need_crc || (long_frame && wr_crc == rx_crc));

    dasi_crc8 #(
        .DW(16)
    ) u_wr_crc (
        .data_i(cmd),
        .len_i(6'h10),
        .crc_o(wr_crc)
    );

    // register writes land at frame end
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            for (int i = 0; i < `DASI_REG_N; i++)
                regs_q[i] <= `DASI_REG_RESET;
        end
        else if (cs_rise && wr_ok)
        begin
            // top bit one: address and twelve data bits
            regs_q[cmd[`DASI_CMD_ADDR_HI:`DASI_CMD_ADDR_LO]] <=
                cmd[`DASI_CMD_DATA_HI:0];
        end
    end

    // refused writes flagged for one cycle
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
            write_reject_o <= 1'b0;
        else
            write_reject_o <= cs_rise && cmd_valid
                && cmd[`DASI_CMD_RW_BIT] && !wr_ok;
    end

    // a read arms one register word for the next frame only
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            rd_pend_q <= 1'b0;
            rd_addr_q <= 3'h0;
        end
        else if (cs_rise)
        begin
            // top bit zero is a read unless the whole word is zero (idle); low twelve bits otherwise ignored
            rd_pend_q <= cmd_valid && !cmd[`DASI_CMD_RW_BIT]
                && cmd != `DASI_IDLE_CMD;
            rd_addr_q <= cmd[`DASI_CMD_ADDR_HI:`DASI_CMD_ADDR_LO];
        end
    end
    assign reg_read_pending_o = rd_pend_q;

    // ----
    // setup fields
    // ----
    assign setup1 = regs_q[`DASI_REG_SETUP1];
    assign setup2 = regs_q[`DASI_REG_SETUP2];
    assign osr_o = setup1[`DASI_S1_OSR_HI:`DASI_S1_OSR_LO];
    assign resolution_boost_enable_o = setup1[`DASI_S1_BOOST_BIT];
    // independent read and write checksum enables
    assign crc_read_en_o = setup1[`DASI_S1_CRC_R_BIT];
    assign crc_write_en_o = setup1[`DASI_S1_CRC_W_BIT];
    assign output_lane_select_o = setup2[`DASI_S2_LANE_BIT];

    // ----
    // payload assembly
    // ----
    // boost only counts with oversampling on
    assign boost = resolution_boost_enable_o && osr_o != 3'h0;
    assign w = boost ? 6'(RESULT_BITS + `DASI_BOOST_BITS)
                     : 6'(RESULT_BITS);
    assign a_l = data_a_q << (6'h12 - w);
    assign b_l = data_b_q << (6'h12 - w);
    assign ab = {a_l, 18'h0_0000} | ({b_l, 18'h0_0000} >> w);
    assign reg_word = {1'b0, rd_addr_q, regs_q[rd_addr_q]};
    // one checksum engine serves results and register words
    assign crc_msg = rd_pend_q ? {reg_word, 20'h0_0000} : ab;
    assign crc_len = rd_pend_q ? 6'h10 : 6'(w + w);

    dasi_crc8 #(
        .DW(36)
    ) u_rd_crc (
        .data_i(crc_msg),
        .len_i(crc_len),
        .crc_o(rd_crc)
    );
    assign rd_crc_m = crc_read_en_o ? rd_crc : 8'h00;

    // lines built per mode; checksum always on the first output
    always_comb
    begin
        line0_d = '0;
        line1_d = '0;
        if (rd_pend_q)
        begin
            // register word replaces results for one frame
            line0_d = {reg_word, rd_crc_m, 20'h0_0000};
        end
        else if (output_lane_select_o)
        begin
            // A then B back to back, checksum behind
            line0_d = {ab, 8'h00}
                | ({rd_crc_m, 36'h0_0000_0000} >> (w + w));
        end
        else
        begin
            // A on the first output, B on the second
            line0_d = {a_l, 26'h000_0000}
                | ({rd_crc_m, 36'h0_0000_0000} >> w);
            line1_d = {b_l, 26'h000_0000};
        end
    end

    // lines change only between frames, so a frame sees them still
    always_ff @(posedge core_clk_i or posedge sys_rst_i)
    begin
        if (sys_rst_i)
        begin
            line0_q <= '0;
            line1_q <= '0;
        end
        else if (cs_s && cs_d_q)
        begin
            // result of the last finished conversion is next out
            line0_q <= line0_d;
            line1_q <= line1_d;
        end
    end
endmodule // dasi_top
`default_nettype wire

/* File: verif/dasi_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// checker on the top ports
// ----
module dasi_top_chk (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    // link pins
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic first_serial_output_o,
    input wire logic first_serial_output_oe_o,
    input wire logic second_serial_output_oe_o,
    // converter control and setup
    input wire logic sample_hold_o,
    input wire logic conv_busy_o,
    input wire logic [2:0] osr_o,
    input wire logic resolution_boost_enable_o,
    input wire logic output_lane_select_o,
    input wire logic crc_read_en_o,
    input wire logic crc_write_en_o,
    input wire logic write_reject_o
);
    // all setup outputs in one vector
    logic [6:0] cfg;
    assign cfg = {osr_o, resolution_boost_enable_o, output_lane_select_o,
        crc_read_en_o, crc_write_en_o};
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    chk_lane_a_oe: assert property (
        first_serial_output_oe_o == !spi_cs_n_i)
        else $error("lane a enable does not follow select");
    chk_lane_b_oe: assert property (
        second_serial_output_oe_o == (!spi_cs_n_i && !output_lane_select_o))
        else $error("lane b enable wrong for lane mode");
    chk_sample_start: assert property (
        $fell(spi_cs_n_i) |-> ##[1:5] sample_hold_o)
        else $error("no sample pulse after select fall");
    chk_sample_pulse: assert property (
        sample_hold_o |-> !spi_cs_n_i ##1 !sample_hold_o)
        else $error("sample pulse malformed");
    chk_conv_time: assert property (
        sample_hold_o |-> ##28 conv_busy_o ##[3:6] !conv_busy_o)
        else $error("conversion time wrong");
    chk_cfg_idle: assert property (
        $changed(cfg) |-> spi_cs_n_i && $past(spi_cs_n_i, 2))
        else $error("setup changed inside a frame");
    chk_reject_pulse: assert property (
        write_reject_o |-> spi_cs_n_i ##1 !write_reject_o)
        else $error("reject pulse malformed");
    chk_reject_keep: assert property (
        write_reject_o |-> $stable(cfg) [*3])
        else $error("refused write changed setup");
    chk_shift_edge: assert property (
        $changed(first_serial_output_o) && !spi_cs_n_i
        && !$past(spi_cs_n_i) |-> spi_sclk_i)
        else $error("lane a changed off the rising edge");
endmodule // dasi_top_chk
bind dasi_top dasi_top_chk u_chk (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
    .first_serial_output_o(first_serial_output_o),
    .first_serial_output_oe_o(first_serial_output_oe_o),
    .second_serial_output_oe_o(second_serial_output_oe_o),
    .sample_hold_o(sample_hold_o), .conv_busy_o(conv_busy_o),
    .osr_o(osr_o), .resolution_boost_enable_o(resolution_boost_enable_o),
    .output_lane_select_o(output_lane_select_o),
    .crc_read_en_o(crc_read_en_o), .crc_write_en_o(crc_write_en_o),
    .write_reject_o(write_reject_o)
);
`default_nettype wire

/* File: verif/dasi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----
// host model: link master, 64 ns clock
// ----
module dasi_host_model (
    // pins driven by the host
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o,
    // device lanes
    input wire logic lane_a_i,
    input wire logic lane_b_i
);
    // idle: deselected, clock standing still
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        sdi_o = 1'b1;
    end
    // one frame of n clocks, command right aligned, lanes caught msb first
    task automatic xfer(input int n, input logic [63:0] cmd,
        output logic [63:0] ra, output logic [63:0] rb);
        ra = '0;
        rb = '0;
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            sdi_o = cmd[n-1-i];
            #32;
            ra[63-i] = lane_a_i;
            rb[63-i] = lane_b_i;
            sclk_o = 1'b1;
            #32;
            sclk_o = 1'b0;
        end
        #32;
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o; // released line shows the inverse
        #200;
    endtask
endmodule // dasi_host_model
`default_nettype wire

/* File: verif/dasi_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dasi_top_tb;
    logic core_clk_i, sys_rst_i, cs_n, sclk, sdi;
    wire logic lane_a, lane_a_oe, lane_b, lane_b_oe, sample, busy;
    wire logic boost, lane_sel, crc_r, crc_w, rej, pend;
    wire logic [2:0] osr;
    wire logic pin_a, pin_b;
    logic [17:0] conv_a, conv_b;
    logic [63:0] ra, rb;
    logic [6:0] cfg;
    int errors = 0;
    int check_count = 0;
    int rej_cnt = 0;
    int r0;
    localparam logic [17:0] VA = 18'h2_5a3c;
    localparam logic [17:0] VB = 18'h1_c3a5;
    // setup1, setup2 and clock count per readback case
    logic [11:0] t_s1 [9] = '{12'h000, 12'h400, 12'h0c4, 12'h4c4,
        12'h004, 12'h000, 12'h400, 12'h0c4, 12'h4c4};
    logic [11:0] t_s2 [9] = '{12'h000, 12'h000, 12'h000, 12'h000,
        12'h000, 12'h100, 12'h100, 12'h100, 12'h100};
    int t_n [9] = '{16, 24, 18, 26, 16, 32, 40, 36, 44};
    assign cfg = {osr, boost, lane_sel, crc_r, crc_w};
    assign pin_a = lane_a_oe ? lane_a : 1'bz;
    assign pin_b = lane_b_oe ? lane_b : 1'bz;
    dasi_top #(.RESULT_BITS(16)) dut (
        .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_sdi_i(sdi),
        .first_serial_output_o(lane_a), .first_serial_output_oe_o(lane_a_oe),
        .second_serial_output_o(lane_b), .second_serial_output_oe_o(lane_b_oe),
        .sample_hold_o(sample), .conv_busy_o(busy),
        .conv_a_i(conv_a), .conv_b_i(conv_b), .osr_o(osr),
        .resolution_boost_enable_o(boost), .output_lane_select_o(lane_sel),
        .crc_read_en_o(crc_r), .crc_write_en_o(crc_w),
        .write_reject_o(rej), .reg_read_pending_o(pend));
    dasi_host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi),
        .lane_a_i(pin_a), .lane_b_i(pin_b));
    // core clock, 8 ns
    initial
    begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    // count refused writes
    always @(posedge core_clk_i)
        if (rej === 1'b1)
            rej_cnt <= rej_cnt + 1;
    task automatic close_out();
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] got,
        input logic [63:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask
    // checksum, preset all ones, msb first
    function automatic logic [7:0] crc8(input logic [63:0] d, input int len);
        logic [7:0] c;
        c = 8'hff;
        for (int i = len - 1; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic frame(input int n, input logic [63:0] cmd);
        @(posedge core_clk_i);
        #3;
        host.xfer(n, cmd, ra, rb);
    endtask
    // register write: m 0 plain, 1 good checksum, 2 bad checksum
    task automatic wr(input logic [2:0] a, input logic [11:0] d, input int m);
        logic [15:0] w;
        w = {1'b1, a, d};
        if (m == 0)
            frame(16, {48'h0, w});
        else
            frame(24, {40'h0, w, crc8({48'h0, w}, 16)
                ^ {7'h0, m == 2}});
    endtask
    // set up a mode and read one result back a frame late
    task automatic rdb(input logic [11:0] s1, input logic [11:0] s2,
        input int n);
        logic [35:0] d;
        logic [63:0] ea;
        logic [7:0] c;
        int w;
        int la;
        w = (s1[2] && s1[8:6] != 3'h0) ? 18 : 16;
        d = (w == 18) ? {VA, VB} : {4'h0, VA[15:0], VB[15:0]};
        c = crc8({28'h0, d}, 2 * w);
        la = s2[8] ? 2 * w : w;
        ea = s2[8] ? {28'h0, d} : {28'h0, d} >> w;
        ea = ea << (64 - la);
        if (s1[10])
            ea = ea | ({56'h0, c} << (56 - la));
        wr(3'h1, s1, 0);
        wr(3'h2, s2, 0);
        check("cfg", cfg, {s1[8:6], s1[2], s2[8], s1[10], s1[11]});
        conv_a = VA;
        conv_b = VB;
        frame(16, 64'h0);
        conv_a = ~VA;
        conv_b = ~VB;
        frame(n, 64'h0);
        check("lane_a", ra >> (64 - n), ea >> (64 - n));
        if (!s2[8])
            check("lane_b", rb >> (64 - w),
                {28'h0, d} & ((64'h1 << w) - 1));
    endtask
    // hang guard
    initial
    begin
        #500_000;
        errors++;
        close_out();
    end
    initial
    begin
        sys_rst_i = 1'b1;
        conv_a = 18'h0;
        conv_b = 18'h0;
        repeat (5) @(posedge core_clk_i);
        #3;
        sys_rst_i = 1'b0;
        repeat (4) @(posedge core_clk_i);
        check("cfg", cfg, 7'h0);
        check("oe", {lane_a_oe, lane_b_oe}, 2'h0);
        for (int i = 0; i < 9; i++)
            rdb(t_s1[i], t_s2[i], t_n[i]);
        check("busy", busy, 1'b0);
        wr(3'h1, 12'h400, 0);
        frame(16, 64'h1000);
        check("pend", pend, 1'b1);
        frame(24, 64'h0);
        check("reg", ra >> 40, {16'h1400, crc8(64'h1400, 16)});
        check("pend", pend, 1'b0);
        r0 = rej_cnt;
        wr(3'h1, 12'h800, 0);
        check("crc_w", crc_w, 1'b0);
        wr(3'h1, 12'h800, 2);
        wr(3'h1, 12'h800, 1);
        check("crc_w", crc_w, 1'b1);
        wr(3'h1, 12'h000, 0);
        wr(3'h1, 12'h000, 2);
        check("crc_w", crc_w, 1'b1);
        check("rej", rej_cnt - r0, 4);
        wr(3'h1, 12'h000, 1);
        check("crc_w", crc_w, 1'b0);
        close_out();
    end
endmodule // dasi_top_tb
`default_nettype wire
